// ### lcr_cfg.svh
// Offsets, field positions, reset values and timing counts of the local registers
`ifndef LCR_CFG_SVH
`define LCR_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFS_LOCAL_CONTROL 8'h00
`define OFS_PIN_CONFIG 8'h04
`define OFS_UART_MIRROR 8'h08

// ----------------------------------------------------------------------
// local_control fields
// ----------------------------------------------------------------------
`define LC_PD_FILTER_LO 5
`define LC_PD_FILTER_HI 7
`define LC_CB_STATUS_EN 23
`define LC_PROM_CLK 24
`define LC_PROM_SEL 25
`define LC_PROM_OUT 26
`define LC_PROM_IN 27
`define LC_PROM_VALID 28
`define LC_RELOAD 29

// ----------------------------------------------------------------------
// pin_config fields
// ----------------------------------------------------------------------
`define PC_PIN_A_LO 0
`define PC_PIN_B_LO 2
`define PC_PME_A 4
`define PC_PME_B 5
`define PC_PD_A 6
`define PC_PD_B 7
`define PC_RESET 8'h00

// ----------------------------------------------------------------------
// uart_status_mirror fields and reset values
// ----------------------------------------------------------------------
`define UM_RX_LO 0
`define UM_TX_LO 8
`define UM_IRQ_LO 16
`define UM_GOOD 27
`define UM_LEVEL_RESET 8'h00
`define UM_IRQ_RESET 6'h01
`define LSR_ERR_FIFO 7
`define LSR_OVERRUN 1

// ----------------------------------------------------------------------
// Power-down filter timing
// ----------------------------------------------------------------------
`define CLK_HZ 40000000
`define PD_DELAY_S_1 129
`define PD_DELAY_S_2 129
`define PD_DELAY_S_3 518

`endif

// ### lcr_pkg.sv
// Types shared by the local configuration register bank
package lcr_pkg;

    // Multi-purpose pin mode encodings
    typedef enum logic [1:0] {
        PIN_IN_TRUE = 2'h0,
        PIN_IN_INV = 2'h1,
        PIN_OUT_LOW = 2'h2,
        PIN_OUT_HIGH = 2'h3
    } pin_mode_t;

    // Power-down filter states, one-hot
    typedef enum logic [2:0] {
        PD_IDLE = 3'h1,
        PD_WAIT = 3'h2,
        PD_DONE = 3'h4
    } pd_state_t;

endpackage : lcr_pkg

// ### multi_pin.sv
// One multi-purpose pin: sync, polarity, output driver
`timescale 1ns/1ps
module multi_pin (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Configuration
    input wire logic [1:0] mode,
    // Pad
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe,
    // Internal state
    output logic state
);
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic out;
        logic oe;
    } mp_state_t;

    mp_state_t r;
    mp_state_t next_r;

    always_comb begin
        next_r = r;
        next_r.sync1 = pin_in;
        next_r.sync2 = r.sync1;
        // Input modes release the pad
        next_r.oe = mode[1];
        next_r.out = mode[1] & mode[0];
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign pin_out = r.out;
    assign pin_oe = r.oe;
    assign state = r.sync2 ^ (mode == lcr_pkg::PIN_IN_INV);
endmodule : multi_pin

// ### pd_filter.sv
// Power-down request filter with selectable delay
`timescale 1ns/1ps
`include "lcr_cfg.svh"
module pd_filter #(
    parameter int unsigned CLK_HZ = `CLK_HZ,
    parameter int unsigned DELAY_S_1 = `PD_DELAY_S_1,
    parameter int unsigned DELAY_S_2 = `PD_DELAY_S_2,
    parameter int unsigned DELAY_S_3 = `PD_DELAY_S_3
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Control
    input wire logic [2:0] delay_sel,
    input wire logic request,
    // Result
    output logic accepted
);
    localparam logic [47:0] TICKS_1 = 48'(CLK_HZ) * 48'(DELAY_S_1);
    localparam logic [47:0] TICKS_2 = 48'(CLK_HZ) * 48'(DELAY_S_2);
    localparam logic [47:0] TICKS_3 = 48'(CLK_HZ) * 48'(DELAY_S_3);

    initial begin
        if (CLK_HZ == 0) begin
            $error("pd_filter: clock rate must be nonzero");
        end
    end

    typedef struct packed {
        lcr_pkg::pd_state_t st;
        logic [47:0] count;
    } pf_state_t;

    pf_state_t r;
    pf_state_t next_r;
    logic [47:0] limit;

    always_comb begin
        next_r = r;
        case (delay_sel[1:0])
            2'h1: limit = TICKS_1;
            2'h2: limit = TICKS_2;
            default: limit = TICKS_3;
        endcase
        // A dropped request or disabled filter restarts the wait
        if (!request || delay_sel == 3'h0) begin
            next_r.st = lcr_pkg::PD_IDLE;
            next_r.count = '0;
        end else begin
            case (r.st)
                lcr_pkg::PD_IDLE: begin
                    next_r.count = '0;
                    next_r.st = delay_sel[2] ? lcr_pkg::PD_DONE
                                             : lcr_pkg::PD_WAIT;
                end
                lcr_pkg::PD_WAIT: begin
                    next_r.count = r.count + 48'h1;
                    if (r.count >= limit) begin
                        next_r.st = lcr_pkg::PD_DONE;
                    end
                end
                lcr_pkg::PD_DONE: next_r.st = lcr_pkg::PD_DONE;
                default: next_r.st = lcr_pkg::PD_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            r <= '{st: lcr_pkg::PD_IDLE, count: '0};
        end else begin
            r <= next_r;
        end
    end

    assign accepted = (r.st == lcr_pkg::PD_DONE);
endmodule : pd_filter

// ### local_config_regs.sv
// Local configuration registers: control, pin config, UART mirror
//
// Function
// - Control bit 23 routes interrupts and wake events via card status fields.
// - Control bit 24 drives the serial PROM clock pin directly.
// - Control bit 25 drives PROM chip select high when set.
// - Control bit 26 appears on the PROM serial data output pin.
// - Read-only bit 27 returns PROM serial input level; resets to one.
// - Read-only bit 28 reads one when PROM header was valid.
// - Writing one to bit 29 starts reload; clears when read finishes.
// - Pin config bits 1:0 set pin A input/inverted/output modes.
// - Pin config bits 3:2 set pin B with same encodings.
// - Pin config bit 4 lets pin A active state set PME status.
// - Pin config bit 5 lets pin B set PME status.
// - Pin config bit 6 lets pin A request power-down via filter.
// - Pin config bit 7 lets pin B request power-down via filter.
// - Mirror bits 7:0 show receive FIFO level; reset 00h.
// - Mirror bits 15:8 show transmit FIFO level; reset 00h.
// - Mirror bits 21:16 show UART interrupt source; reset 01h.
// - Mirror bit 27 is good-data flag from source and line status.
// - Pin internal state is raw level or inverse per its mode.
// - Control bits 7:5 pick filter delay; zero disables, 1XX immediate.
`timescale 1ns/1ps
`include "lcr_cfg.svh"
module local_config_regs #(
    parameter int unsigned CLK_HZ = `CLK_HZ,
    parameter int unsigned PD_DELAY_S_1 = `PD_DELAY_S_1,
    parameter int unsigned PD_DELAY_S_2 = `PD_DELAY_S_2,
    parameter int unsigned PD_DELAY_S_3 = `PD_DELAY_S_3
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [3:0] reg_byte_en,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_rvalid,
    // Serial PROM pins
    output logic prom_serial_clock,
    output logic prom_select,
    output logic prom_serial_out,
    input wire logic prom_serial_in,
    // PROM loader status
    input wire logic prom_header_valid,
    input wire logic prom_load_done,
    output logic reload_request,
    // Multi-purpose pins
    input wire logic multi_pin_a_in,
    output logic multi_pin_a_out,
    output logic multi_pin_a_oe,
    input wire logic multi_pin_b_in,
    output logic multi_pin_b_out,
    output logic multi_pin_b_oe,
    // UART status inputs
    input wire logic [7:0] rx_fill_level,
    input wire logic [7:0] tx_fill_level,
    input wire logic [5:0] uart_irq_source,
    input wire logic [7:0] uart_line_status,
    // Power management
    output logic cb_status_enable,
    output logic pme_set,
    output logic powerdown_request,
    output logic multi_pin_a_state,
    output logic multi_pin_b_state
);
    initial begin
        if (CLK_HZ < 1000) begin
            $error("local_config_regs: clock rate too low");
        end
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [2:0] pd_filter;
        logic cb_en;
        logic prom_clk;
        logic prom_sel;
        logic prom_out;
        logic prom_in_s1;
        logic prom_in_s2;
        logic prom_valid;
        logic reload;
        logic [7:0] pin_cfg;
        logic [7:0] rx_lvl;
        logic [7:0] tx_lvl;
        logic [5:0] irq_src;
        logic good;
        logic [31:0] rdata;
        logic rvalid;
        logic pme;
        logic pd_req;
        logic st_a;
        logic st_b;
    } regs_state_t;

    regs_state_t r;
    regs_state_t next_r;

    logic pin_a_state;
    logic pin_b_state;
    logic pd_accepted;
    logic pd_source;
    logic good_now;
    logic [31:0] ctl_word;
    logic [31:0] mirror_word;

    // ------------------------------------------------------------------
    // Pins and filter
    // ------------------------------------------------------------------
    multi_pin u_pin_a (
        .core_clk(core_clk),
        .reset(reset),
        .mode(r.pin_cfg[`PC_PIN_A_LO +: 2]),
        .pin_in(multi_pin_a_in),
        .pin_out(multi_pin_a_out),
        .pin_oe(multi_pin_a_oe),
        .state(pin_a_state)
    );

    multi_pin u_pin_b (
        .core_clk(core_clk),
        .reset(reset),
        .mode(r.pin_cfg[`PC_PIN_B_LO +: 2]),
        .pin_in(multi_pin_b_in),
        .pin_out(multi_pin_b_out),
        .pin_oe(multi_pin_b_oe),
        .state(pin_b_state)
    );

    // Polarity already folded into the internal states
    assign pd_source = (r.pin_cfg[`PC_PD_A] & pin_a_state)
                     | (r.pin_cfg[`PC_PD_B] & pin_b_state);

    pd_filter #(
        .CLK_HZ(CLK_HZ),
        .DELAY_S_1(PD_DELAY_S_1),
        .DELAY_S_2(PD_DELAY_S_2),
        .DELAY_S_3(PD_DELAY_S_3)
    ) u_pd_filter (
        .core_clk(core_clk),
        .reset(reset),
        .delay_sel(r.pd_filter),
        .request(pd_source),
        .accepted(pd_accepted)
    );

    // ------------------------------------------------------------------
    // Good-data evaluation
    // ------------------------------------------------------------------
    // Sources none, rx data, rx timeout, tx empty; no pending errors
    always_comb begin
        good_now = 1'b0;
        if (uart_irq_source == 6'h01 || uart_irq_source == 6'h04 ||
            uart_irq_source == 6'h0c || uart_irq_source == 6'h02) begin
            good_now = ~uart_line_status[`LSR_ERR_FIFO]
                     & ~uart_line_status[`LSR_OVERRUN];
        end
    end

    // ------------------------------------------------------------------
    // Read words
    // ------------------------------------------------------------------
    always_comb begin
        ctl_word = '0;
        ctl_word[`LC_PD_FILTER_HI:`LC_PD_FILTER_LO] = r.pd_filter;
        ctl_word[`LC_CB_STATUS_EN] = r.cb_en;
        ctl_word[`LC_PROM_CLK] = r.prom_clk;
        ctl_word[`LC_PROM_SEL] = r.prom_sel;
        ctl_word[`LC_PROM_OUT] = r.prom_out;
        ctl_word[`LC_PROM_IN] = r.prom_in_s2;
        ctl_word[`LC_PROM_VALID] = r.prom_valid;
        ctl_word[`LC_RELOAD] = r.reload;
        mirror_word = '0;
        mirror_word[`UM_RX_LO +: 8] = r.rx_lvl;
        mirror_word[`UM_TX_LO +: 8] = r.tx_lvl;
        mirror_word[`UM_IRQ_LO +: 6] = r.irq_src;
        mirror_word[`UM_GOOD] = r.good;
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_r = r;
        next_r.prom_in_s1 = prom_serial_in;
        next_r.prom_in_s2 = r.prom_in_s1;
        next_r.prom_valid = prom_header_valid;
        next_r.rx_lvl = rx_fill_level;
        next_r.tx_lvl = tx_fill_level;
        next_r.irq_src = uart_irq_source;
        next_r.good = good_now;
        next_r.pme = (r.pin_cfg[`PC_PME_A] & pin_a_state)
                   | (r.pin_cfg[`PC_PME_B] & pin_b_state);
        next_r.pd_req = pd_accepted;
        next_r.st_a = pin_a_state;
        next_r.st_b = pin_b_state;
        next_r.rvalid = reg_read;
        next_r.rdata = r.rdata;

        // Loader finishing clears the trigger
        if (prom_load_done) begin
            next_r.reload = 1'b0;
        end

        if (reg_write) begin
            if (reg_addr == `OFS_LOCAL_CONTROL) begin
                if (reg_byte_en[0]) begin
                    next_r.pd_filter = reg_wdata[7:5];
                end
                if (reg_byte_en[2]) begin
                    next_r.cb_en = reg_wdata[`LC_CB_STATUS_EN];
                end
                if (reg_byte_en[3]) begin
                    next_r.prom_clk = reg_wdata[`LC_PROM_CLK];
                    next_r.prom_sel = reg_wdata[`LC_PROM_SEL];
                    next_r.prom_out = reg_wdata[`LC_PROM_OUT];
                    // Start wins over a same-cycle finish
                    if (reg_wdata[`LC_RELOAD]) begin
                        next_r.reload = 1'b1;
                    end
                end
            end else if (reg_addr == `OFS_PIN_CONFIG) begin
                if (reg_byte_en[0]) begin
                    next_r.pin_cfg = reg_wdata[7:0];
                end
            end
        end

        if (reg_read) begin
            if (reg_addr == `OFS_LOCAL_CONTROL) begin
                next_r.rdata = ctl_word;
            end else if (reg_addr == `OFS_PIN_CONFIG) begin
                next_r.rdata = {24'h000000, r.pin_cfg};
            end else if (reg_addr == `OFS_UART_MIRROR) begin
                next_r.rdata = mirror_word;
            end else begin
                next_r.rdata = '0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset) begin
            r <= '0;
            r.prom_in_s1 <= 1'b1;
            r.prom_in_s2 <= 1'b1;
            r.pin_cfg <= `PC_RESET;
            r.rx_lvl <= `UM_LEVEL_RESET;
            r.tx_lvl <= `UM_LEVEL_RESET;
            r.irq_src <= `UM_IRQ_RESET;
            r.good <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign reg_rdata = r.rdata;
    assign reg_rvalid = r.rvalid;
    assign prom_serial_clock = r.prom_clk;
    assign prom_select = r.prom_sel;
    assign prom_serial_out = r.prom_out;
    assign reload_request = r.reload;
    assign cb_status_enable = r.cb_en;
    assign pme_set = r.pme;
    assign powerdown_request = r.pd_req;
    assign multi_pin_a_state = r.st_a;
    assign multi_pin_b_state = r.st_b;
endmodule : local_config_regs

// ### local_config_regs_props.sv
// Port-level checker for the local configuration register bank
`timescale 1ns/1ps
module local_config_regs_props (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [3:0] reg_byte_en,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    // PROM and loader
    input wire logic prom_serial_clock,
    input wire logic prom_select,
    input wire logic prom_serial_out,
    input wire logic prom_serial_in,
    input wire logic prom_load_done,
    input wire logic reload_request,
    // Pins and status
    input wire logic multi_pin_a_out,
    input wire logic multi_pin_a_oe,
    input wire logic multi_pin_b_out,
    input wire logic multi_pin_b_oe,
    input wire logic [7:0] rx_fill_level,
    input wire logic [7:0] tx_fill_level,
    input wire logic [5:0] uart_irq_source,
    input wire logic [7:0] uart_line_status,
    input wire logic cb_status_enable
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    logic wr_ctl;
    logic wr_pin;
    logic good_now;
    assign wr_ctl = reg_write && reg_addr == 8'h00;
    assign wr_pin = reg_write && reg_addr == 8'h04 && reg_byte_en[0];
    assign good_now = !uart_line_status[7] && !uart_line_status[1] &&
        uart_irq_source inside {6'h01, 6'h04, 6'h0c, 6'h02};
    sequence s_rd_mirror;
        reg_read && reg_addr == 8'h08;
    endsequence
    // Mirror lags its inputs a cycle, so they must hold across the read
    sequence s_uart_steady;
        !$past(reset) && $stable(rx_fill_level) && $stable(tx_fill_level)
            && $stable(uart_irq_source) && $stable(uart_line_status);
    endsequence
    sequence s_in_steady;
        $stable(prom_serial_in) [*4];
    endsequence
    property p_cb_en;
        wr_ctl && reg_byte_en[2] |=> cb_status_enable == $past(reg_wdata[23]);
    endproperty
    a_cb_en: assert property (p_cb_en) else $error("cb enable");
    property p_prom_pins;
        wr_ctl && reg_byte_en[3] |=> {prom_serial_out, prom_select,
            prom_serial_clock} == $past(reg_wdata[26:24]);
    endproperty
    a_prom_pins: assert property (p_prom_pins)
        else $error("prom pins");
    property p_reload_clr;
        reload_request && prom_load_done
            && !(wr_ctl && reg_byte_en[3] && reg_wdata[29]) |=> !reload_request;
    endproperty
    a_reload_clr: assert property (p_reload_clr)
        else $error("reload clear");
    // Pad drivers register the mode a cycle after pin_config lands
    property p_pin_a;
        wr_pin |=> ##1 multi_pin_a_oe == $past(reg_wdata[1], 2)
            && multi_pin_a_out == (&$past(reg_wdata[1:0], 2));
    endproperty
    a_pin_a: assert property (p_pin_a) else $error("pin a");
    property p_pin_b;
        wr_pin |=> ##1 multi_pin_b_oe == $past(reg_wdata[3], 2)
            && multi_pin_b_out == (&$past(reg_wdata[3:2], 2));
    endproperty
    a_pin_b: assert property (p_pin_b) else $error("pin b");
    property p_mirror;
        s_rd_mirror ##0 s_uart_steady |=> reg_rdata[21:0] == {
            $past(uart_irq_source), $past(tx_fill_level), $past(rx_fill_level)};
    endproperty
    a_mirror: assert property (p_mirror)
        else $error("mirror levels");
    property p_good;
        s_rd_mirror ##0 s_uart_steady |=> reg_rdata[27] == $past(good_now);
    endproperty
    a_good: assert property (p_good) else $error("good data");
    property p_prom_in;
        s_in_steady ##0 (reg_read && reg_addr == 8'h00)
            |=> reg_rdata[27] == $past(prom_serial_in);
    endproperty
    a_prom_in: assert property (p_prom_in) else $error("prom in");
endmodule : local_config_regs_props
bind local_config_regs local_config_regs_props i_local_config_regs_props (
    .core_clk, .reset, .reg_addr, .reg_write, .reg_read, .reg_byte_en,
    .reg_wdata, .reg_rdata, .prom_serial_clock, .prom_select,
    .prom_serial_out, .prom_serial_in, .prom_load_done, .reload_request,
    .multi_pin_a_out, .multi_pin_a_oe, .multi_pin_b_out, .multi_pin_b_oe,
    .rx_fill_level, .tx_fill_level, .uart_irq_source, .uart_line_status,
    .cb_status_enable
);

// ### prom_model.sv
// Behavioural serial PROM and configuration loader
`timescale 1ns/1ps
module prom_model #(
    parameter int unsigned LOAD_CYCLES = 5
) (
    // Clock
    input wire logic core_clk,
    // PROM pins
    input wire logic prom_serial_clock,
    input wire logic prom_select,
    input wire logic prom_serial_out,
    output logic prom_serial_in,
    // Loader
    input wire logic reload_request,
    output logic prom_load_done,
    // Bits shifted in
    output logic [7:0] shifted
);
    logic echo = 1'b0;
    int unsigned wait_cnt = 0;
    initial prom_load_done = 1'b0;
    initial shifted = 8'h00;
    // Pull-up on the data line while deselected
    assign prom_serial_in = prom_select ? echo : 1'b1;
    always @(posedge prom_serial_clock) begin
        if (prom_select) begin
            shifted <= {shifted[6:0], prom_serial_out};
            echo <= ~prom_serial_out;
        end
    end
    always @(posedge core_clk) begin
        prom_load_done <= 1'b0;
        if (reload_request && !prom_load_done) begin
            wait_cnt <= wait_cnt + 1;
            if (wait_cnt == LOAD_CYCLES) begin
                prom_load_done <= 1'b1;
                wait_cnt <= 0;
            end
        end
    end
endmodule : prom_model

// ### local_config_regs_tb_top.sv
// Self-checking bench for the local configuration register bank
`timescale 1ns/1ps
module local_config_regs_tb_top;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [3:0] reg_byte_en = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata;
    logic reg_rvalid, p_clk, p_sel, p_out, p_in, hdr, done, reload;
    logic ext_a = 1'b0;
    logic ext_b = 1'b0;
    logic pin_a, pin_b, a_out, a_oe, b_out, b_oe, cb_en, pme, pd_req, sa, sb;
    logic [7:0] rx = 8'h00;
    logic [7:0] tx = 8'h00;
    logic [5:0] irq = 6'h01;
    logic [7:0] ls = 8'h00;
    logic [7:0] shifted;
    logic [31:0] v;
    logic [5:0] codes [6] = '{6'h01, 6'h04, 6'h0c, 6'h02, 6'h06, 6'h00};
    int n_errors = 0;
    int n_compared = 0;
    int cycles = 0;
    int seed = 88;
    assign pin_a = a_oe ? a_out : ext_a;
    assign pin_b = b_oe ? b_out : ext_b;
    initial hdr = 1'b0;
    initial begin
        forever #12.5 core_clk = ~core_clk;
    end
    // Short filter counts: delay code 001 waits 1000 cycles
    local_config_regs #(.CLK_HZ(1000), .PD_DELAY_S_1(1), .PD_DELAY_S_2(1),
        .PD_DELAY_S_3(1)) i_local_config_regs (
        .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
        .reg_write(reg_write), .reg_read(reg_read), .reg_byte_en(reg_byte_en),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .prom_serial_clock(p_clk), .prom_select(p_sel),
        .prom_serial_out(p_out), .prom_serial_in(p_in),
        .prom_header_valid(hdr), .prom_load_done(done),
        .reload_request(reload), .multi_pin_a_in(pin_a),
        .multi_pin_a_out(a_out), .multi_pin_a_oe(a_oe),
        .multi_pin_b_in(pin_b), .multi_pin_b_out(b_out),
        .multi_pin_b_oe(b_oe), .rx_fill_level(rx), .tx_fill_level(tx),
        .uart_irq_source(irq), .uart_line_status(ls),
        .cb_status_enable(cb_en), .pme_set(pme), .powerdown_request(pd_req),
        .multi_pin_a_state(sa), .multi_pin_b_state(sb));
    prom_model i_prom_model (.core_clk(core_clk), .prom_serial_clock(p_clk),
        .prom_select(p_sel), .prom_serial_out(p_out), .prom_serial_in(p_in),
        .reload_request(reload), .prom_load_done(done), .shifted(shifted));
    task automatic report_and_stop();
        $display("Compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop
    task automatic check32(input logic [31:0] got, exp, mask);
        n_compared++;
        if ((got & mask) !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got & mask, exp);
        end
    endtask : check32
    task automatic check1(input logic got, exp);
        check32({31'h0, got}, {31'h0, exp}, 32'h1);
    endtask : check1
    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] be);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_byte_en = be;
        reg_write = 1'b1;
        @(negedge core_clk);
        reg_write = 1'b0;
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, m);
        @(negedge core_clk);
        reg_addr = a;
        reg_read = 1'b1;
        @(negedge core_clk);
        reg_read = 1'b0;
        check1(reg_rvalid, 1'b1);
        check32(reg_rdata, e, m);
    endtask : rd_chk
    function automatic logic [2:0] pin_exp(logic [1:0] m, logic ext);
        return {m[1], m == 2'h3, m[1] ? m == 2'h3 : ext ^ m[0]};
    endfunction : pin_exp
    task automatic pd_try(input logic [2:0] code, input logic [7:0] cfg,
                          input logic pad, input int n, input logic e);
        wr(8'h00, {24'h0, code, 5'h0}, 4'h1);
        wr(8'h04, {24'h0, cfg}, 4'h1);
        ext_a = pad;
        ext_b = pad;
        tick(n);
        check1(pd_req, e);
    endtask : pd_try
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            n_errors++;
            report_and_stop();
        end
    end
    initial begin
        logic [1:0] ma, mb;
        logic c4, c5, pe;
        repeat (12) @(negedge core_clk);
        reset = 1'b0;
        rd_chk(8'h00, 32'h0800_0000, '1);
        rd_chk(8'h04, 32'h0, '1);
        rd_chk(8'h08, 32'h0801_0000, '1);
        wr(8'h0c, '1, 4'hf);
        rd_chk(8'h0c, 32'h0, '1);
        $display("test reset_values done");
        wr(8'h00, 32'h0080_0000, 4'h4);
        check1(cb_en, 1'b1);
        wr(8'h00, 32'h0, 4'h0);
        check1(cb_en, 1'b1);
        wr(8'h00, 32'h0, 4'h4);
        check1(cb_en, 1'b0);
        $display("test cb_enable done");
        v = $random(seed);
        for (int i = 7; i >= 0; i--) begin
            wr(8'h00, {5'h0, v[i], 2'b10, 24'h0}, 4'h8);
            check1(p_sel, 1'b1);
            wr(8'h00, {5'h0, v[i], 2'b11, 24'h0}, 4'h8);
        end
        check32({24'h0, shifted}, {24'h0, v[7:0]}, '1);
        tick(4);
        rd_chk(8'h00, {4'h0, ~v[0], 27'h0}, 32'h0800_0000);
        wr(8'h00, 32'h0, 4'h8);
        check1(p_sel, 1'b0);
        tick(4);
        rd_chk(8'h00, 32'h0800_0000, 32'h0800_0000);
        hdr = 1'b1;
        tick(2);
        rd_chk(8'h00, 32'h1000_0000, 32'h1000_0000);
        $display("test prom_port done");
        wr(8'h00, 32'h2000_0000, 4'h8);
        check1(reload, 1'b1);
        rd_chk(8'h00, 32'h2000_0000, 32'h2000_0000);
        for (int i = 0; i < 30 && reload === 1'b1; i++) tick(1);
        check1(reload, 1'b0);
        rd_chk(8'h00, 32'h0, 32'h2000_0000);
        $display("test reload done");
        for (int m = 0; m < 16; m++) begin
            ma = m[1:0];
            mb = m[3:2];
            c4 = $random(seed);
            c5 = $random(seed);
            ext_a = $random(seed);
            ext_b = $random(seed);
            wr(8'h04, {26'h0, c5, c4, mb, ma}, 4'h1);
            tick(6);
            pe = (c4 & pin_exp(ma, ext_a)) | (c5 & pin_exp(mb, ext_b));
            check32({25'h0, a_oe, a_out, sa, b_oe, b_out, sb, pme},
                {25'h0, pin_exp(ma, ext_a), pin_exp(mb, ext_b), pe},
                '1);
            rd_chk(8'h04, {26'h0, c5, c4, mb, ma}, '1);
        end
        $display("test multi_pins done");
        pd_try(3'h4, 8'h40, 1'b1, 6, 1'b1);
        pd_try(3'h4, 8'h40, 1'b0, 6, 1'b0);
        pd_try(3'h4, 8'h41, 1'b0, 6, 1'b1);
        pd_try(3'h4, 8'h80, 1'b1, 6, 1'b1);
        pd_try(3'h0, 8'hc0, 1'b1, 6, 1'b0);
        pd_try(3'h1, 8'h40, 1'b1, 990, 1'b0);
        tick(20);
        check1(pd_req, 1'b1);
        pd_try(3'h0, 8'h00, 1'b0, 2, 1'b0);
        $display("test powerdown done");
        for (int k = 0; k < 12; k++) begin
            rx = $random(seed);
            tx = $random(seed);
            irq = codes[{$random(seed)} % 6];
            ls = $random(seed) & 32'h82;
            tick(2);
            rd_chk(8'h08, {4'h0, (irq inside {6'h01, 6'h04, 6'h0c, 6'h02})
                && ls == 8'h00, 5'h0, irq, tx, rx}, '1);
        end
        $display("test mirror done");
        report_and_stop();
    end
endmodule : local_config_regs_tb_top
